// ===== design/wsc_pkg.sv
// constants and types of the wake, shutdown and clock sequencer
// assumes a single 100 MHz system clock and a 32.768 kHz time base
package wsc_pkg;

  // ---------------------------------------------------------------
  // clock rates
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ      = 100_000_000;
  localparam longint unsigned XTAL_HZ     = 32_768;
  localparam longint unsigned FAST_CLK_HZ = 2_457_600;
  localparam longint unsigned CLK_NS      = 10;
  localparam longint unsigned NS_PER_S    = 1_000_000_000;

  // ---------------------------------------------------------------
  // widths and types
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned DIV_W  = 12;
  localparam int unsigned HALF_W = 5;
  typedef logic [CNT_W-1:0]  wsc_cnt_t;
  typedef logic [DIV_W-1:0]  wsc_div_t;
  typedef logic [HALF_W-1:0] wsc_half_t;

  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_WAKE  = 4'h2,
    ST_AWAKE = 4'h4,
    ST_SHUT  = 4'h8
  } wsc_state_t;

  // ---------------------------------------------------------------
  // times as printed, in ns
  // ---------------------------------------------------------------
  localparam longint unsigned RESET_TIMEOUT_NS = 1_540_000_000;
  localparam longint unsigned WAKE_MIN_NS      = 1_000;
  localparam longint unsigned SUPPLY_ON_NS     = 1_000;
  localparam longint unsigned FAST_ON_NS       = 31_250_000;
  localparam longint unsigned INT_DELAY_NS     = 7_820_000;
  localparam longint unsigned FAST_OFF_NS      = 1_000_000;
  localparam longint unsigned SUP_OFF_NS       = 2_930_000;

  function automatic longint unsigned ns_to_ticks(longint unsigned ns);
    return (ns * XTAL_HZ + NS_PER_S - 1) / NS_PER_S;
  endfunction

  function automatic longint unsigned ns_to_cyc(longint unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // ---------------------------------------------------------------
  // derived counts
  // ---------------------------------------------------------------
  // nearest integer divider: tick rate is 32.765 kHz, 0.01 % slow
  localparam wsc_div_t TICK_DIV = wsc_div_t'((CLK_HZ + XTAL_HZ / 2) / XTAL_HZ);
  // 2.5 MHz, the closest even division of the system clock
  localparam wsc_half_t FAST_HALF = wsc_half_t'(CLK_HZ / (2 * FAST_CLK_HZ));
  localparam wsc_cnt_t RESET_TICKS = wsc_cnt_t'(ns_to_ticks(RESET_TIMEOUT_NS));
  localparam wsc_cnt_t FAST_ON_TICKS  = wsc_cnt_t'(ns_to_ticks(FAST_ON_NS));
  localparam wsc_cnt_t INT_TICKS      = wsc_cnt_t'(ns_to_ticks(INT_DELAY_NS));
  localparam wsc_cnt_t FAST_OFF_TICKS = wsc_cnt_t'(ns_to_ticks(FAST_OFF_NS));
  localparam wsc_cnt_t SUP_OFF_TICKS  = wsc_cnt_t'(ns_to_ticks(SUP_OFF_NS));
  localparam wsc_cnt_t WAKE_MIN_CYC   = wsc_cnt_t'(ns_to_cyc(WAKE_MIN_NS));
  localparam wsc_cnt_t SUPPLY_ON_CYC  = wsc_cnt_t'(ns_to_cyc(SUPPLY_ON_NS));

endpackage

// ===== design/wsc_delay.sv
// saturating delay counter, advanced by a one-cycle enable
// assumes i_run is held for the whole wait; dropping it restarts
module wsc_delay #(
  parameter wsc_pkg::wsc_cnt_t LIMIT = wsc_pkg::wsc_cnt_t'(1)
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_run,
  output logic      o_done
);
  import wsc_pkg::*;

  typedef struct packed {
    wsc_cnt_t cnt;
    logic     done;
  } wsc_dly_s_t;

  wsc_dly_s_t q;
  wsc_dly_s_t d;

  always_comb begin
    d = q;
    if (!i_run) begin
      d.cnt = '0;
    end else if (i_tick && q.cnt != LIMIT) begin
      d.cnt = q.cnt + wsc_cnt_t'(1);
    end
    d.done = i_run && (d.cnt == LIMIT);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_done = q.done;
endmodule

// ===== design/wsc_sequencer.sv
// wake, shutdown and fast clock sequencer of the acquisition device
// assumes analog comparator results arrive as synchronous levels
//
// Operation
// RULE_01 - reset held 1.54 s after supply good
// RULE_02 - select bit picks 1.8 V or 2.7 V
// RULE_03 - wake input held low at least 1 us
// RULE_04 - supply enable rises 1 us after wake
// RULE_05 - fast clock needs reset, supply, PLL
// RULE_06 - fast clock starts 31.25 ms after both
// RULE_07 - fast clock always starts low
// RULE_08 - interrupt 7.82 ms after fast clock on
// RULE_09 - fast clock stops after delay past shutdown
// RULE_10 - supply enable falls 2.93 ms after shutdown
// RULE_11 - supply stays on while PLL is on
// RULE_12 - flag low supply outside sleep below 2.75 V
// RULE_13 - either wake input leaves sleep for standby
// RULE_14 - supply enable low while sleeping
// RULE_15 - interrupt on PLL ready, detect, alarm
// RULE_16 - delays counted in 32.768 kHz ticks; the 1 us wake and supply-on delays count system clock cycles
// RULE_17 - host shuts down after its own clean-up
module wsc_sequencer #(
  parameter wsc_pkg::wsc_cnt_t RESET_TIMEOUT = wsc_pkg::RESET_TICKS
) (
  input  wire logic I_CLOCK,
  input  wire logic I_RST_N,
  input  wire logic I_SUPPLY_ABOVE_1V8,
  input  wire logic I_SUPPLY_ABOVE_2V7,
  input  wire logic I_SUPPLY_GOOD,
  input  wire logic I_MONITOR_THRESHOLD_SELECT,
  input  wire logic I_WAKE_INPUT_A_N,
  input  wire logic I_WAKE_INPUT_B_N,
  input  wire logic I_PLL_ON,
  input  wire logic I_SHUTDOWN_CMD,
  input  wire logic I_SIGNAL_DETECT,
  input  wire logic I_ALARM,
  input  wire logic I_INT_CLEAR,
  output logic      O_RESET_OUT,
  output logic      O_RESET_OE_N,
  output logic      O_SUPPLY_OFF_N,
  output logic      O_FAST_CLOCK_OUT,
  output logic      O_INT_N,
  output logic      O_LOW_SUPPLY,
  output logic      O_AWAKE
);
  import wsc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wsc_state_t st;
    wsc_div_t   div;
    logic       tick;
    logic       rel;
    logic       sup;
    logic       fast_en;
    logic       fast;
    wsc_half_t  half;
    logic       fast_off;
    logic       int_prev;
    logic       int_n;
    logic       low;
    logic       awake;
  } wsc_top_s_t;

  localparam wsc_top_s_t RESET_STATE = '{
    st: ST_SLEEP, div: '0, tick: 1'b0, rel: 1'b0, sup: 1'b0,
    fast_en: 1'b0, fast: 1'b0, half: '0, fast_off: 1'b0,
    int_prev: 1'b0, int_n: 1'b1, low: 1'b0, awake: 1'b0};

  wsc_top_s_t q;
  wsc_top_s_t d;

  logic supply_ok;
  logic fon_run;
  logic wake_low;
  logic rst_done;
  logic fon_done;
  logic int_done;
  logic wake_done;
  logic son_done;
  logic foff_done;
  logic sdn_done;

  assign supply_ok = I_MONITOR_THRESHOLD_SELECT ? I_SUPPLY_ABOVE_1V8
                                                : I_SUPPLY_ABOVE_2V7; // RULE_02
  assign fon_run   = q.rel && I_SUPPLY_GOOD && I_PLL_ON
                     && !q.fast_off; // RULE_05
  assign wake_low  = (q.st == ST_SLEEP)
                     && (!I_WAKE_INPUT_A_N || !I_WAKE_INPUT_B_N); // RULE_13

  // ---------------------------------------------------------------
  // delay counters
  // ---------------------------------------------------------------
  wsc_delay #(.LIMIT(RESET_TIMEOUT)) u_rst (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(q.tick),
    .i_run(supply_ok), .o_done(rst_done)); // RULE_01
  wsc_delay #(.LIMIT(FAST_ON_TICKS)) u_fon (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(q.tick),
    .i_run(fon_run), .o_done(fon_done)); // RULE_06
  wsc_delay #(.LIMIT(INT_TICKS)) u_int (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(q.tick),
    .i_run(q.fast_en), .o_done(int_done)); // RULE_08
  // short glitches on the wake pins never count as a wake event
  wsc_delay #(.LIMIT(WAKE_MIN_CYC)) u_wake (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(1'b1),
    .i_run(wake_low), .o_done(wake_done)); // RULE_03
  wsc_delay #(.LIMIT(SUPPLY_ON_CYC)) u_son (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(1'b1),
    .i_run(q.st == ST_WAKE), .o_done(son_done)); // RULE_04
  wsc_delay #(.LIMIT(FAST_OFF_TICKS)) u_foff (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(q.tick),
    .i_run(q.st == ST_SHUT), .o_done(foff_done)); // RULE_09
  wsc_delay #(.LIMIT(SUP_OFF_TICKS)) u_sdn (
    .i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_tick(q.tick),
    .i_run(q.st == ST_SHUT), .o_done(sdn_done)); // RULE_10

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // time base at the crystal rate
    if (q.div == TICK_DIV - wsc_div_t'(1)) begin // RULE_16
      d.div  = '0;
      d.tick = 1'b1;
    end else begin
      d.div  = q.div + wsc_div_t'(1);
      d.tick = 1'b0;
    end
    d.rel = supply_ok && rst_done; // RULE_01

    unique case (q.st)
      ST_SLEEP: begin
        if (wake_done) begin // RULE_13
          d.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (son_done) begin // RULE_04
          d.st = ST_AWAKE;
        end
      end
      ST_AWAKE: begin
        if (I_SHUTDOWN_CMD) begin
          d.st = ST_SHUT;
        end
      end
      ST_SHUT: begin
        // pll still on: hold the converter on until it is turned off
        if (sdn_done && !I_PLL_ON) begin // RULE_10 RULE_11
          d.st = ST_SLEEP;
        end
      end
      default: begin
        d.st = ST_SLEEP;
      end
    endcase
    d.sup = (d.st == ST_AWAKE) || (d.st == ST_SHUT); // RULE_14
    d.awake = (d.st != ST_SLEEP); // RULE_13

    // fast clock gating and divider
    if (d.st == ST_SHUT && foff_done) begin // RULE_09
      d.fast_off = 1'b1;
    end else if (d.st != ST_SHUT) begin
      d.fast_off = 1'b0;
    end
    d.fast_en = fon_done && fon_run && !d.fast_off; // RULE_05
    if (!d.fast_en) begin // RULE_07
      d.fast = 1'b0;
      d.half = '0;
    end else if (q.half == FAST_HALF - wsc_half_t'(1)) begin
      d.fast = !q.fast;
      d.half = '0;
    end else begin
      d.half = q.half + wsc_half_t'(1);
    end

    // interrupt: a new event beats a clear in the same cycle
    d.int_prev = int_done;
    if ((int_done && !q.int_prev) || I_SIGNAL_DETECT
        || I_ALARM) begin // RULE_08 RULE_15
      d.int_n = 1'b0;
    end else if (I_INT_CLEAR) begin
      d.int_n = 1'b1;
    end

    d.low = (d.st != ST_SLEEP) && !I_SUPPLY_GOOD; // RULE_12
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // open drain: only ever pulls low, enable active low
  assign O_RESET_OUT      = 1'b0;
  assign O_RESET_OE_N     = q.rel;
  assign O_SUPPLY_OFF_N   = q.sup;
  assign O_FAST_CLOCK_OUT = q.fast;
  assign O_INT_N          = q.int_n;
  assign O_LOW_SUPPLY     = q.low;
  assign O_AWAKE          = q.awake;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_rst_low;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      !supply_ok |=> !q.rel;
  endproperty
  a_rst_low: assert property (p_rst_low) // RULE_01
    else $error("reset released while supply below threshold");

  property p_thresh;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_MONITOR_THRESHOLD_SELECT && !I_SUPPLY_ABOVE_1V8)
      || (!I_MONITOR_THRESHOLD_SELECT && !I_SUPPLY_ABOVE_2V7)
      |=> O_RESET_OE_N == 1'b0;
  endproperty
  a_thresh: assert property (p_thresh) // RULE_02
    else $error("wrong reset threshold used");

  property p_supply_on;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      $rose(q.sup) |-> $past(q.st == ST_WAKE) && $past(son_done);
  endproperty
  a_supply_on: assert property (p_supply_on) // RULE_04
    else $error("supply enable rose without wake delay");

  property p_fast_gate;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      q.fast_en |-> $past(q.rel && I_SUPPLY_GOOD && I_PLL_ON);
  endproperty
  a_fast_gate: assert property (p_fast_gate) // RULE_05
    else $error("fast clock enabled without all conditions");

  property p_fast_first_low;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      $rose(q.fast_en) |-> !q.fast [*8];
  endproperty
  a_fast_first_low: assert property (p_fast_first_low) // RULE_07
    else $error("fast clock did not start low");

  property p_supply_pll;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      q.sup && I_PLL_ON |=> q.sup;
  endproperty
  a_supply_pll: assert property (p_supply_pll) // RULE_11
    else $error("supply enable dropped while pll on");

  property p_supply_off;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      $fell(q.sup) |-> $past(sdn_done) && $past(q.st == ST_SHUT);
  endproperty
  a_supply_off: assert property (p_supply_off) // RULE_10
    else $error("supply enable fell without shutdown delay");

  property p_low_flag;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      !I_SUPPLY_GOOD && q.st == ST_AWAKE |=> q.low;
  endproperty
  a_low_flag: assert property (p_low_flag) // RULE_12
    else $error("low supply not flagged");

  property p_wake;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      q.st == ST_SLEEP && wake_done |=> q.st == ST_WAKE ##101 q.sup;
  endproperty
  a_wake: assert property (p_wake) // RULE_13
    else $error("wake did not leave sleep in time");

  property p_sleep_off;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      q.st == ST_SLEEP |-> !O_SUPPLY_OFF_N;
  endproperty
  a_sleep_off: assert property (p_sleep_off) // RULE_14
    else $error("supply enable high in sleep");

  property p_int_event;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      I_SIGNAL_DETECT || I_ALARM |=> !O_INT_N;
  endproperty
  a_int_event: assert property (p_int_event) // RULE_15
    else $error("interrupt missed an event");

  property p_tick;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      q.tick |=> !q.tick [*8];
  endproperty
  a_tick: assert property (p_tick) // RULE_16
    else $error("time base ticks too often");
endmodule

// ===== verification/wsc_supply_model.sv
// analog supply comparators and wake pins seen by the sequencer
// assumes the bench sets the supply level in millivolts
module wsc_supply_model (
  input  wire logic [15:0] i_level_mv,
  input  wire logic        i_pull_a,
  input  wire logic        i_pull_b,
  output logic             o_above_1v8,
  output logic             o_above_2v7,
  output logic             o_good,
  output logic             o_wake_a_n,
  output logic             o_wake_b_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // comparators
  // ---------------------------------------------------------------
  assign o_above_1v8 = (i_level_mv >= 16'h0708);
  assign o_above_2v7 = (i_level_mv >= 16'h0a8c);
  assign o_good      = (i_level_mv >= 16'h0abe);

  // ---------------------------------------------------------------
  // wake pins
  // ---------------------------------------------------------------
  // internal pull-up: a released pin reads high, never the last value
  assign o_wake_a_n = ~i_pull_a;
  assign o_wake_b_n = ~i_pull_b;
endmodule

// ===== verification/wsc_sequencer_test.sv
// self-checking bench of the wake, shutdown and clock sequencer
// assumes a shortened reset timeout; long fast clock waits not reached
module wsc_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wsc_pkg::*;

  localparam int TK = int'(TICK_DIV);
  localparam int RT = 4;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sel = 1'b0;
  logic        pll = 1'b0;
  logic        shut = 1'b0;
  logic        det = 1'b0;
  logic        alarm = 1'b0;
  logic        clr = 1'b0;
  logic        pull_a = 1'b0;
  logic        pull_b = 1'b0;
  logic [15:0] mv = 16'h0bb8;
  logic        a18, a27, good, wa_n, wb_n;
  logic        rst_out, oe_n, sup_n, fclk, int_n, low, awake;
  int          err_total = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  wsc_supply_model i_supply (
    .i_level_mv (mv),
    .i_pull_a   (pull_a),
    .i_pull_b   (pull_b),
    .o_above_1v8(a18),
    .o_above_2v7(a27),
    .o_good     (good),
    .o_wake_a_n (wa_n),
    .o_wake_b_n (wb_n)
  );

  wsc_sequencer #(.RESET_TIMEOUT(wsc_cnt_t'(RT))) i_dut (
    .I_CLOCK                   (clk),
    .I_RST_N                   (rst_n),
    .I_SUPPLY_ABOVE_1V8        (a18),
    .I_SUPPLY_ABOVE_2V7        (a27),
    .I_SUPPLY_GOOD             (good),
    .I_MONITOR_THRESHOLD_SELECT(sel),
    .I_WAKE_INPUT_A_N          (wa_n),
    .I_WAKE_INPUT_B_N          (wb_n),
    .I_PLL_ON                  (pll),
    .I_SHUTDOWN_CMD            (shut),
    .I_SIGNAL_DETECT           (det),
    .I_ALARM                   (alarm),
    .I_INT_CLEAR               (clr),
    .O_RESET_OUT               (rst_out),
    .O_RESET_OE_N              (oe_n),
    .O_SUPPLY_OFF_N            (sup_n),
    .O_FAST_CLOCK_OUT          (fclk),
    .O_INT_N                   (int_n),
    .O_LOW_SUPPLY              (low),
    .O_AWAKE                   (awake)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sampling at the edge sees the settled value of the previous edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic cur(input int w);
    case (w)
      0: return oe_n;
      1: return sup_n;
      2: return awake;
      default: return fclk;
    endcase
  endfunction

  task automatic chk(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_for(input int w, input logic v, input int lim,
                          output int n);
    n = 0;
    while (cur(w) !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask

  task automatic hold_ok(input int w, input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      step(1);
      if (cur(w) !== v) bad++;
    end
    chk(bad == 0, 1'b1);
  endtask

  task automatic set_pull(input int w, input logic v);
    if (w == 0) pull_a <= v;
    else pull_b <= v;
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    step(2);
    rst_n <= 1'b1;
    step(1);
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_after_reset;
    chk(oe_n, 1'b0);
    chk(rst_out, 1'b0);
    chk(sup_n, 1'b0);
    chk(int_n, 1'b1);
    chk(awake, 1'b0);
    chk(fclk, 1'b0);
    chk(low, 1'b0);
  endtask

  // first tick may land anywhere, so the window spans two ticks
  task automatic t_timeout;
    int n;
    step((RT - 1) * TK - 10);
    chk(oe_n, 1'b0);
    wait_for(0, 1'b1, 2 * TK + 20, n);
    chk(n < 2 * TK + 20, 1'b1);
  endtask

  task automatic t_threshold;
    mv <= 16'h07d0;
    step(3);
    chk(oe_n, 1'b0);
    chk(low, 1'b0);
    sel <= 1'b1;
    t_timeout();
    mv <= 16'h0bb8;
    sel <= 1'b0;
    step(3);
  endtask

  task automatic t_wake(input int w);
    int n;
    do_reset();
    set_pull(w, 1'b1);
    step(50);
    set_pull(w, 1'b0);
    step(300);
    chk(awake, 1'b0);
    set_pull(w, 1'b1);
    wait_for(2, 1'b1, 200, n);
    chk(n >= 98 && n <= 106, 1'b1);
    chk(sup_n, 1'b0);
    wait_for(1, 1'b1, 200, n);
    chk(n >= 95 && n <= 110, 1'b1);
    set_pull(w, 1'b0);
  endtask

  task automatic t_low_supply;
    mv <= 16'h07d0;
    step(3);
    chk(low, 1'b1);
    mv <= 16'h0bb8;
    step(3);
    chk(low, 1'b0);
  endtask

  task automatic t_interrupt;
    det <= 1'b1;
    step(1);
    det <= 1'b0;
    step(1);
    chk(int_n, 1'b0);
    step(5);
    chk(int_n, 1'b0);
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
    step(1);
    chk(int_n, 1'b1);
    alarm <= 1'b1;
    clr <= 1'b1;
    step(1);
    alarm <= 1'b0;
    clr <= 1'b0;
    step(1);
    chk(int_n, 1'b0);
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
    step(1);
    chk(int_n, 1'b1);
  endtask

  // the 31.25 ms start is out of reach; only an early start is caught
  task automatic t_fast_clock;
    pll <= 1'b1;
    hold_ok(3, 1'b0, 20000);
    shut <= 1'b1;
    step(1);
    shut <= 1'b0;
    hold_ok(1, 1'b1, 20000);
  endtask

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    t_after_reset();
    t_timeout();
    t_threshold();
    for (int w = 0; w < 2; w++) begin
      t_wake(w);
    end
    t_low_supply();
    t_interrupt();
    t_fast_clock();
    finish_test();
  end

  initial begin
    step(80000);
    err_total++;
    finish_test();
  end
endmodule
